// ### hdl/rcm_mode_control.sv
// Top of the mode control register bank with registered mode outputs
`timescale 1ns/10ps
`default_nettype none
module rcm_mode_control (
  input  wire logic                       CLK_SYS_I,
  input  wire logic                       RESET_N_I,
  input  wire logic                       WR_STROBE_I,
  input  wire logic [rcm_pkg::ADDR_W-1:0] WR_ADDR_I,
  input  wire logic [rcm_pkg::DATA_W-1:0] WR_DATA_I,
  input  wire logic                       FIELD_START_I,
  input  wire logic                       BLOCK_COL_LSB_I,
  input  wire logic                       BLOCK_ROW_LSB_I,
  input  wire logic                       STORE_WRITE_REQ_I,
  output logic                            EST_FIELD_ALT_O,
  output logic                            FILM_SOURCE_SELECT_O,
  output logic [1:0]                      UPCONVERSION_QUALITY_O,
  output logic                            UPC_FULL_O,
  output logic                            UPC_ECONOMY_O,
  output logic                            UPC_LEGACY_A_O,
  output logic                            UPC_LEGACY_B_O,
  output logic                            DOUBLE_OUTPUT_ENABLE_O,
  output logic                            VERT_PEAKING_ENABLE_O,
  output logic                            CROSS_SWITCH_MASTER_ENABLE_O,
  output logic                            CROSS_SWITCH_ACTIVE_O,
  output logic                            LUMA_COMPRESSION_ENABLE_O,
  output logic                            LUMA_DECOMPRESSION_ENABLE_O,
  output logic                            CURRENT_CHECKER_PHASE_O,
  output logic                            PREVIOUS_CHECKER_PHASE_O,
  output logic                            ESTIMATE_BLOCK_O,
  output logic                            NEW_FIELD_FLAG_O,
  output logic                            FIELD_STORE_WRITE_ENABLE_O,
  output logic                            FIELD_STORE_WRITE_O,
  output logic                            FIRST_STORE_PARITY_O,
  output logic                            LINE_TREE_SWAP_O,
  output logic                            CUR_FIELD_TREE_RIGHT_O,
  output logic                            FRAME_LINES_TREE_RIGHT_O,
  output logic signed [1:0]               VERTICAL_VECTOR_OFFSET_O
);

  logic [7:0] ctl1_act;
  logic [7:0] ctl2_act;

  logic       dec_upc_full;
  logic       dec_upc_economy;
  logic       dec_upc_legacy_a;
  logic       dec_upc_legacy_b;
  logic       dec_peaking;
  logic       dec_cross_active;
  logic       dec_estimate;
  logic       dec_store_write;
  logic       dec_cur_right;
  logic       dec_frame_right;

  // Unmapped addresses are ignored; nothing reads back
  wire hit_ctl1 = WR_STROBE_I & rcm_pkg::rcm_addr_hit(WR_ADDR_I, rcm_pkg::MODE_CONTROL_ONE_OFF);
  wire hit_ctl2 = WR_STROBE_I & rcm_pkg::rcm_addr_hit(WR_ADDR_I, rcm_pkg::FIELD_SEQUENCE_CONTROL_OFF);

  // Field-synchronous registers: mid-field writes wait for the next field start
  rcm_shadow_reg #(
    .WIDTH     (rcm_pkg::DATA_W),
    .RESET_VAL (rcm_pkg::MODE_CONTROL_ONE_RST)
  ) u_ctl1 (
    .clk_i     (CLK_SYS_I),
    .reset_n_i (RESET_N_I),
    .wr_hit_i  (hit_ctl1),
    .wr_data_i (WR_DATA_I),
    .apply_i   (FIELD_START_I),
    .active_o  (ctl1_act)
  );

  rcm_shadow_reg #(
    .WIDTH     (rcm_pkg::DATA_W),
    .RESET_VAL (rcm_pkg::FIELD_SEQUENCE_CONTROL_RST)
  ) u_ctl2 (
    .clk_i     (CLK_SYS_I),
    .reset_n_i (RESET_N_I),
    .wr_hit_i  (hit_ctl2),
    .wr_data_i (WR_DATA_I),
    .apply_i   (FIELD_START_I),
    .active_o  (ctl2_act)
  );

  rcm_mode_decode u_decode (
    .ctl1_i                   (ctl1_act),
    .ctl2_i                   (ctl2_act),
    .block_col_lsb_i          (BLOCK_COL_LSB_I),
    .block_row_lsb_i          (BLOCK_ROW_LSB_I),
    .store_write_req_i        (STORE_WRITE_REQ_I),
    .upc_full_o               (dec_upc_full),
    .upc_economy_o            (dec_upc_economy),
    .upc_legacy_a_o           (dec_upc_legacy_a),
    .upc_legacy_b_o           (dec_upc_legacy_b),
    .vert_peaking_enable_o    (dec_peaking),
    .cross_switch_active_o    (dec_cross_active),
    .estimate_block_o         (dec_estimate),
    .field_store_write_o      (dec_store_write),
    .cur_field_tree_right_o   (dec_cur_right),
    .frame_lines_tree_right_o (dec_frame_right)
  );

  logic [7:0] ctl1_out_ff;
  logic [7:0] ctl2_out_ff;
  logic [9:0] dec_ff;
  wire  [9:0] nxt_dec = {dec_upc_full, dec_upc_economy, dec_upc_legacy_a, dec_upc_legacy_b, dec_peaking,
                         dec_cross_active, dec_estimate, dec_store_write, dec_cur_right, dec_frame_right};

  // Output flops keep glitches of the decode away from the datapath
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RESET_N_I)
    begin
      ctl1_out_ff <= rcm_pkg::MODE_CONTROL_ONE_RST;
      ctl2_out_ff <= rcm_pkg::FIELD_SEQUENCE_CONTROL_RST;
      // Decode of both registers at zero for the upper-left block
      dec_ff      <= 10'h229;
    end
    else
    begin
      ctl1_out_ff <= ctl1_act;
      ctl2_out_ff <= ctl2_act;
      dec_ff      <= nxt_dec;
    end
  end

  assign EST_FIELD_ALT_O              = ctl1_out_ff[rcm_pkg::EST_ALT_BIT]; // RL1
  assign FILM_SOURCE_SELECT_O         = ctl1_out_ff[rcm_pkg::FILM_BIT];    // RL2
  assign UPCONVERSION_QUALITY_O       = ctl1_out_ff[rcm_pkg::UPC_MSB:rcm_pkg::UPC_LSB]; // RL3
  assign DOUBLE_OUTPUT_ENABLE_O       = ctl1_out_ff[rcm_pkg::DOUBLE_BIT];  // RL4
  assign CROSS_SWITCH_MASTER_ENABLE_O = ctl1_out_ff[rcm_pkg::EMBRACE_BIT]; // RL5
  assign LUMA_COMPRESSION_ENABLE_O    = ctl1_out_ff[rcm_pkg::COMP_BIT];    // RL7
  assign LUMA_DECOMPRESSION_ENABLE_O  = ctl1_out_ff[rcm_pkg::DECOMP_BIT];  // RL8
  assign CURRENT_CHECKER_PHASE_O      = ctl2_out_ff[rcm_pkg::CUR_PHASE_BIT];
  assign PREVIOUS_CHECKER_PHASE_O     = ctl2_out_ff[rcm_pkg::PREV_PHASE_BIT];
  assign NEW_FIELD_FLAG_O             = ctl2_out_ff[rcm_pkg::NEW_FIELD_BIT];
  assign FIELD_STORE_WRITE_ENABLE_O   = ctl2_out_ff[rcm_pkg::STORE_WE_BIT]; // RL13
  assign FIRST_STORE_PARITY_O         = ctl2_out_ff[rcm_pkg::PARITY_BIT];
  assign LINE_TREE_SWAP_O             = ctl2_out_ff[rcm_pkg::SWAP_BIT];     // RL15
  // Two's complement view of the offset code: 01 is +1, 11 is -1
  assign VERTICAL_VECTOR_OFFSET_O     = $signed(ctl2_out_ff[rcm_pkg::OFFS_MSB:rcm_pkg::OFFS_LSB]); // RL17

  assign UPC_FULL_O               = dec_ff[9];
  assign UPC_ECONOMY_O            = dec_ff[8];
  assign UPC_LEGACY_A_O           = dec_ff[7];
  assign UPC_LEGACY_B_O           = dec_ff[6];
  assign VERT_PEAKING_ENABLE_O    = dec_ff[5];
  assign CROSS_SWITCH_ACTIVE_O    = dec_ff[4];
  assign ESTIMATE_BLOCK_O         = dec_ff[3];
  assign FIELD_STORE_WRITE_O      = dec_ff[2];
  assign CUR_FIELD_TREE_RIGHT_O   = dec_ff[1];
  assign FRAME_LINES_TREE_RIGHT_O = dec_ff[0];

  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RESET_N_I);

  wire wr1_apply = hit_ctl1 & FIELD_START_I;
  wire wr2_apply = hit_ctl2 & FIELD_START_I;

  est_alt_a: assert property (wr1_apply |-> ##2 EST_FIELD_ALT_O == $past(WR_DATA_I[0], 2)) // RL1
    else $error("estimator alternation not taken from write");

  film_select_a: assert property (wr1_apply |-> ##2 FILM_SOURCE_SELECT_O == $past(WR_DATA_I[1], 2)) // RL2
    else $error("film select not taken from write");

  upc_quality_a: assert property (wr1_apply |-> ##2 (UPCONVERSION_QUALITY_O == $past(WR_DATA_I[3:2], 2)) // RL3
                                  && ((UPC_LEGACY_B_O && !UPC_FULL_O) == ($past(WR_DATA_I[3:2], 2) == 2'h3))
                                  && (UPC_ECONOMY_O == ($past(WR_DATA_I[3:2], 2) == 2'h1)))
    else $error("upconversion quality decode wrong");

  double_peaking_a: assert property (##1 (DOUBLE_OUTPUT_ENABLE_O != VERT_PEAKING_ENABLE_O)) // RL4
    else $error("double output must disable vertical peaking");

  cross_switch_a: assert property (CROSS_SWITCH_ACTIVE_O == (CROSS_SWITCH_MASTER_ENABLE_O && LINE_TREE_SWAP_O)) // RL5
    else $error("cross switch without master enable and swap");

  luma_dpcm_a: assert property (wr1_apply |-> ##2 {LUMA_DECOMPRESSION_ENABLE_O, LUMA_COMPRESSION_ENABLE_O} // RL7 RL8
                                == $past(WR_DATA_I[7:6], 2))
    else $error("luma DPCM enables not taken from write");

  checker_block_a: assert property (##1 ESTIMATE_BLOCK_O == // RL10
                                    ($past(BLOCK_COL_LSB_I ^ BLOCK_ROW_LSB_I) == $past(ctl2_act[0])))
    else $error("checker block selection wrong");

  store_write_a: assert property (FIELD_STORE_WRITE_O |-> // RL13
                                  $past(STORE_WRITE_REQ_I) && FIELD_STORE_WRITE_ENABLE_O)
    else $error("store written while disabled");

  tree_swap_a: assert property (wr2_apply |-> ##2 (CUR_FIELD_TREE_RIGHT_O == $past(WR_DATA_I[5], 2)) // RL15
                                && (FRAME_LINES_TREE_RIGHT_O != CUR_FIELD_TREE_RIGHT_O))
    else $error("line tree assignment wrong");

  vec_offset_a: assert property (wr2_apply |-> ##2 // RL17
                                 VERTICAL_VECTOR_OFFSET_O == $signed($past(WR_DATA_I[7:6], 2)))
    else $error("vertical offset not taken from write");

  hold_value_a: assert property (!FIELD_START_I |=> $stable(ctl1_act) && $stable(ctl2_act)) // RL20
    else $error("mode registers changed without field start");

  film_swap_c: cover property (FILM_SOURCE_SELECT_O && CROSS_SWITCH_ACTIVE_O);
  legacy_upc_c: cover property (UPC_LEGACY_A_O && LUMA_COMPRESSION_ENABLE_O);
  double_out_c: cover property (DOUBLE_OUTPUT_ENABLE_O && !VERT_PEAKING_ENABLE_O);
  phase_toggle_c: cover property (CURRENT_CHECKER_PHASE_O ##[1:50] !CURRENT_CHECKER_PHASE_O);
  ctl1_apply_c: cover property (wr1_apply);

endmodule : rcm_mode_control
`default_nettype wire

// ### hdl/rcm_pkg.sv
// Package with register map, field positions and reset values of the mode control bank
//
// Function
// [RL1] Mode one bit 0: 0 line alternating estimators, 1 field alternating estimators.
// [RL2] Mode one bit 1: 0 video camera mode, 1 film mode.
// [RL3] Bits 3..2 quality: 00 full, 01 economy DPCM, 10/11 legacy emulations.
// [RL4] Bit 4 double output disables vertical peaking; host sets it as bus select AND.
// [RL5] Bit 5 embrace master; cross-switch happens only when tree swap is also set.
// [RL6] Host keeps embrace off except film with third store or legacy compressed film.
// [RL7] Mode one bit 6 enables luma DPCM compression on store writes.
// [RL8] Mode one bit 7 enables luma DPCM decompression on store reads.
// [RL9] Host toggles current checker phase on every new field from first store.
// [RL10] Phase 0 estimates checkerboard from upper-left block, phase 1 the complement.
// [RL11] Host loads previous phase with phase used for last prediction store estimate.
// [RL12] Host sets new field flag: toggles in doubling, high in progressive output.
// [RL13] Sequence bit 3 enables writes to original and interpolated stores, else none.
// [RL14] Host sets bit 4 to detected parity of field leaving first store.
// [RL15] Swap set: current field to right tree, frame lines to left tree.
// [RL16] Host sets swap only in film with third store, and then sets embrace.
// [RL17] Bits 7..6 give right tree vertical offset; larger means less delayed lines.
// [RL18] Host programs offset -1 odd left, +1 even left, 0 progressive, dynamic film.
// [RL19] Host sets double output only when second bus select chooses code 11.
// [RL20] Write-only registers hold written values and drive modes until next write; the code keeps the old mode after a write until the next field start.
package rcm_pkg;

  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 8;

  localparam logic [ADDR_W-1:0] MODE_CONTROL_ONE_OFF       = 9'h026;
  localparam logic [ADDR_W-1:0] FIELD_SEQUENCE_CONTROL_OFF = 9'h027;

  localparam logic [DATA_W-1:0] MODE_CONTROL_ONE_RST       = 8'h00;
  localparam logic [DATA_W-1:0] FIELD_SEQUENCE_CONTROL_RST = 8'h00;

  // Mode control one fields
  localparam int unsigned EST_ALT_BIT   = 0;
  localparam int unsigned FILM_BIT      = 1;
  localparam int unsigned UPC_LSB       = 2;
  localparam int unsigned UPC_MSB       = 3;
  localparam int unsigned DOUBLE_BIT    = 4;
  localparam int unsigned EMBRACE_BIT   = 5;
  localparam int unsigned COMP_BIT      = 6;
  localparam int unsigned DECOMP_BIT    = 7;

  // Field sequence control fields
  localparam int unsigned CUR_PHASE_BIT  = 0;
  localparam int unsigned PREV_PHASE_BIT = 1;
  localparam int unsigned NEW_FIELD_BIT  = 2;
  localparam int unsigned STORE_WE_BIT   = 3;
  localparam int unsigned PARITY_BIT     = 4;
  localparam int unsigned SWAP_BIT       = 5;
  localparam int unsigned OFFS_LSB       = 6;
  localparam int unsigned OFFS_MSB       = 7;

  localparam logic [1:0] UPC_FULL    = 2'h0;
  localparam logic [1:0] UPC_ECONOMY = 2'h1;
  localparam logic [1:0] UPC_LEGACY_A = 2'h2;
  localparam logic [1:0] UPC_LEGACY_B = 2'h3;

  function automatic logic rcm_addr_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] offset);
    rcm_addr_hit = (addr == offset);
  endfunction : rcm_addr_hit

endpackage : rcm_pkg

// ### hdl/rcm_shadow_reg.sv
// Write-only register with a shadow stage applied at field start
`timescale 1ns/10ps
`default_nettype none
module rcm_shadow_reg #(
  parameter int unsigned            WIDTH     = 8,
  parameter logic [WIDTH-1:0]       RESET_VAL = '0
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             wr_hit_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic             apply_i,
  output logic      [WIDTH-1:0] active_o
);

  logic [WIDTH-1:0] shadow_ff;
  logic [WIDTH-1:0] active_ff;
  wire  [WIDTH-1:0] nxt_shadow = wr_hit_i ? wr_data_i : shadow_ff;
  // A write in the apply cycle goes straight through, so it is never lost
  wire  [WIDTH-1:0] nxt_active = apply_i ? nxt_shadow : active_ff;

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      shadow_ff <= RESET_VAL;
      active_ff <= RESET_VAL;
    end
    else
    begin
      shadow_ff <= nxt_shadow;
      active_ff <= nxt_active; // RL20
    end
  end

  assign active_o = active_ff;

endmodule : rcm_shadow_reg
`default_nettype wire

// ### hdl/rcm_mode_decode.sv
// Combinational decode of the active mode registers into datapath controls
`timescale 1ns/10ps
`default_nettype none
module rcm_mode_decode (
  input  wire logic [7:0] ctl1_i,
  input  wire logic [7:0] ctl2_i,
  input  wire logic       block_col_lsb_i,
  input  wire logic       block_row_lsb_i,
  input  wire logic       store_write_req_i,
  output logic            upc_full_o,
  output logic            upc_economy_o,
  output logic            upc_legacy_a_o,
  output logic            upc_legacy_b_o,
  output logic            vert_peaking_enable_o,
  output logic            cross_switch_active_o,
  output logic            estimate_block_o,
  output logic            field_store_write_o,
  output logic            cur_field_tree_right_o,
  output logic            frame_lines_tree_right_o
);

  wire [1:0] upc_code = ctl1_i[rcm_pkg::UPC_MSB:rcm_pkg::UPC_LSB];
  wire       swap     = ctl2_i[rcm_pkg::SWAP_BIT];
  // Upper-left block has even parity, estimated in phase 0
  wire       block_odd = block_col_lsb_i ^ block_row_lsb_i;

  assign upc_full_o            = (upc_code == rcm_pkg::UPC_FULL);     // RL3
  assign upc_economy_o         = (upc_code == rcm_pkg::UPC_ECONOMY);  // RL3
  assign upc_legacy_a_o        = (upc_code == rcm_pkg::UPC_LEGACY_A); // RL3
  assign upc_legacy_b_o        = (upc_code == rcm_pkg::UPC_LEGACY_B); // RL3
  assign vert_peaking_enable_o = !ctl1_i[rcm_pkg::DOUBLE_BIT];        // RL4
  assign cross_switch_active_o = ctl1_i[rcm_pkg::EMBRACE_BIT] & swap; // RL5
  assign estimate_block_o      = (block_odd == ctl2_i[rcm_pkg::CUR_PHASE_BIT]); // RL10
  assign field_store_write_o   = store_write_req_i & ctl2_i[rcm_pkg::STORE_WE_BIT]; // RL13
  assign cur_field_tree_right_o   = swap;  // RL15
  assign frame_lines_tree_right_o = !swap; // RL15

endmodule : rcm_mode_decode
`default_nettype wire

// ### tb/rcm_host_model.sv
// Host model that programs the mode bank through the control front end
`timescale 1ns/10ps
`default_nettype none
module rcm_host_model (
  input  wire logic       clk_i,
  output logic            wr_strobe_o,
  output logic [8:0]      wr_addr_o,
  output logic [7:0]      wr_data_o,
  output logic            field_start_o
);
  initial
  begin
    wr_strobe_o   = 1'b0;
    wr_addr_o     = 9'h1FF;
    wr_data_o     = 8'hFF;
    field_start_o = 1'b0;
  end

  // One byte per request, held for one sampling edge
  task automatic write_reg(input logic [8:0] addr, input logic [7:0] data, input logic fs);
    @(posedge clk_i);
    #1;
    wr_strobe_o   = 1'b1;
    wr_addr_o     = addr;
    wr_data_o     = data;
    field_start_o = fs;
    @(posedge clk_i);
    #1;
    // Released bus shows inverted data, not the last value
    wr_strobe_o   = 1'b0;
    wr_addr_o     = ~addr;
    wr_data_o     = ~data;
    field_start_o = 1'b0;
  endtask : write_reg

  task automatic field_pulse;
    @(posedge clk_i);
    #1;
    field_start_o = 1'b1;
    @(posedge clk_i);
    #1;
    field_start_o = 1'b0;
  endtask : field_pulse

  function automatic logic [7:0] mode_one(input logic est, input logic film, input logic [1:0] upc,
                                          input logic [1:0] bus_sel, input logic comp, input logic decomp);
    mode_one = {decomp, comp, film, &bus_sel, upc, film, est};
  endfunction : mode_one

  // Field sequencing as a host tracks it from field to field
  function automatic logic [7:0] next_seq(input logic [7:0] prev, input logic film,
                                          input logic odd, input logic we);
    logic [7:0] s;
    s[0]   = ~prev[0];
    s[1]   = prev[0];
    s[2]   = ~prev[2];
    s[3]   = we;
    s[4]   = odd;
    s[5]   = film;
    s[7:6] = film ? 2'h0 : (odd ? 2'h3 : 2'h1);
    next_seq = s;
  endfunction : next_seq
endmodule : rcm_host_model
`default_nettype wire

// ### tb/rcm_mode_control_bench.sv
// Self-checking bench for the mode control register bank
`timescale 1ns/10ps
`default_nettype none
module rcm_mode_control_bench;
  logic        clk, reset_n, wr_strobe, field_start, col_lsb, row_lsb, store_req;
  logic [8:0]  wr_addr;
  logic [7:0]  wr_data, s1, s2;
  logic        est_alt, film_sel, upc_full, upc_eco, upc_la, upc_lb, dbl, peak;
  logic        xs_master, xs_active, comp, decomp, cur_ph, prev_ph, est_blk, new_fld;
  logic        we_en, st_wr, parity, swap, cur_right, frame_right;
  logic [1:0]  upc;
  logic signed [1:0] voff;
  int          fail_count;
  int          checked;

  rcm_host_model i_rcm_host_model (.clk_i(clk), .wr_strobe_o(wr_strobe), .wr_addr_o(wr_addr),
    .wr_data_o(wr_data), .field_start_o(field_start));

  rcm_mode_control i_rcm_mode_control (.CLK_SYS_I(clk), .RESET_N_I(reset_n), .WR_STROBE_I(wr_strobe),
    .WR_ADDR_I(wr_addr), .WR_DATA_I(wr_data), .FIELD_START_I(field_start), .BLOCK_COL_LSB_I(col_lsb),
    .BLOCK_ROW_LSB_I(row_lsb), .STORE_WRITE_REQ_I(store_req), .EST_FIELD_ALT_O(est_alt),
    .FILM_SOURCE_SELECT_O(film_sel), .UPCONVERSION_QUALITY_O(upc), .UPC_FULL_O(upc_full),
    .UPC_ECONOMY_O(upc_eco), .UPC_LEGACY_A_O(upc_la), .UPC_LEGACY_B_O(upc_lb),
    .DOUBLE_OUTPUT_ENABLE_O(dbl), .VERT_PEAKING_ENABLE_O(peak), .CROSS_SWITCH_MASTER_ENABLE_O(xs_master),
    .CROSS_SWITCH_ACTIVE_O(xs_active), .LUMA_COMPRESSION_ENABLE_O(comp), .LUMA_DECOMPRESSION_ENABLE_O(decomp),
    .CURRENT_CHECKER_PHASE_O(cur_ph), .PREVIOUS_CHECKER_PHASE_O(prev_ph), .ESTIMATE_BLOCK_O(est_blk),
    .NEW_FIELD_FLAG_O(new_fld), .FIELD_STORE_WRITE_ENABLE_O(we_en), .FIELD_STORE_WRITE_O(st_wr),
    .FIRST_STORE_PARITY_O(parity), .LINE_TREE_SWAP_O(swap), .CUR_FIELD_TREE_RIGHT_O(cur_right),
    .FRAME_LINES_TREE_RIGHT_O(frame_right), .VERTICAL_VECTOR_OFFSET_O(voff));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    if (fail_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // Waits two edges per block position so the registered decode has landed
  task automatic check_all(input logic [7:0] c1, input logic [7:0] c2);
    for (int k = 0; k < 4; k++)
    begin
      col_lsb   = k[1];
      row_lsb   = k[0];
      store_req = k[0];
      repeat (2) @(posedge clk);
      #1;
      check(est_blk, (col_lsb ^ row_lsb) == c2[0]);
      check(st_wr, store_req & c2[3]);
    end
    check(est_alt, c1[0]);
    check(film_sel, c1[1]);
    check({upc, upc_lb, upc_la, upc_eco, upc_full},
          {c1[3:2], c1[3:2] == 2'h3, c1[3:2] == 2'h2, c1[3:2] == 2'h1, c1[3:2] == 2'h0});
    check({dbl, peak}, {c1[4], ~c1[4]});
    check({xs_master, xs_active}, {c1[5], c1[5] & c2[5]});
    check(comp, c1[6]);
    check(decomp, c1[7]);
    check({parity, we_en, new_fld, prev_ph, cur_ph}, c2[4:0]);
    check({swap, cur_right, frame_right}, {c2[5], c2[5], ~c2[5]});
    check({voff}, c2[7:6]);
  endtask : check_all

  initial
  begin
    fail_count = 0;
    checked    = 0;
    reset_n    = 1'b0;
    col_lsb    = 1'b0;
    row_lsb    = 1'b0;
    store_req  = 1'b0;
    s2         = 8'h00;
    repeat (6) @(posedge clk);
    #1;
    check({upc_full, peak, frame_right, est_blk}, 8'h0F);
    check({upc_eco, upc_la, upc_lb, xs_active, st_wr, cur_right, dbl, swap}, 8'h00);
    reset_n = 1'b1;
    check_all(8'h00, 8'h00);
    // Every quality code, both sources, double output only with both select bits
    for (int i = 0; i < 8; i++)
    begin
      s1 = i_rcm_host_model.mode_one(i[0], i[2], i[1:0], {i[2], i[0]}, i[1], i[2] ^ i[0]);
      s2 = i_rcm_host_model.next_seq(s2, i[2], i[1], ~i[0]);
      // Field start rides on either register's write, so both same-cycle paths are used
      if (i[0])
      begin
        i_rcm_host_model.write_reg(rcm_pkg::MODE_CONTROL_ONE_OFF, s1, 1'b0);
        i_rcm_host_model.write_reg(rcm_pkg::FIELD_SEQUENCE_CONTROL_OFF, s2, 1'b1);
      end
      else
      begin
        i_rcm_host_model.write_reg(rcm_pkg::FIELD_SEQUENCE_CONTROL_OFF, s2, 1'b0);
        i_rcm_host_model.write_reg(rcm_pkg::MODE_CONTROL_ONE_OFF, s1, 1'b1);
      end
      check_all(s1, s2);
    end
    // Embrace without swap in legacy film with compression; nothing moves before field start
    i_rcm_host_model.write_reg(rcm_pkg::MODE_CONTROL_ONE_OFF, 8'h6A, 1'b0);
    i_rcm_host_model.write_reg(rcm_pkg::FIELD_SEQUENCE_CONTROL_OFF,
                               i_rcm_host_model.next_seq(s2, 1'b0, 1'b1, 1'b1), 1'b0);
    check_all(s1, s2);
    i_rcm_host_model.field_pulse();
    s2 = i_rcm_host_model.next_seq(s2, 1'b0, 1'b1, 1'b1);
    check_all(8'h6A, s2);
    // Back to back writes, last wins; unmapped address ignored
    i_rcm_host_model.write_reg(rcm_pkg::MODE_CONTROL_ONE_OFF, 8'h5F, 1'b0);
    i_rcm_host_model.write_reg(rcm_pkg::MODE_CONTROL_ONE_OFF, 8'hC3, 1'b0);
    i_rcm_host_model.write_reg(rcm_pkg::FIELD_SEQUENCE_CONTROL_OFF,
                               i_rcm_host_model.next_seq(s2, 1'b0, 1'b0, 1'b0), 1'b0);
    i_rcm_host_model.write_reg(9'h028, 8'hFF, 1'b1);
    s2 = i_rcm_host_model.next_seq(s2, 1'b0, 1'b0, 1'b0);
    check_all(8'hC3, s2);
    tally_and_finish();
  end

  // Guard against a hang anywhere in the sequence
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
endmodule : rcm_mode_control_bench
`default_nettype wire
